// file: dram_odt_termination_control_tb.sv
// dram_odt_termination_control_tb: register-level tests of the controller
`timescale 1ns/1ps
`default_nettype none
module dram_odt_termination_control_tb;
	logic clk;
	logic arst_n;
	logic [4:0] bus_addr;
	logic [31:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [31:0] bus_rdata;
	logic odt;
	logic [2:0] cmd;
	logic [1:0] ba;
	logic [12:0] daddr;
	logic bc4;
	logic [1:0] term;
	logic [7:0] viol;
	logic [31:0] r;
	int mismatches = 0;
	int n_compared = 0;
	int k;
	// refused loads: reserved nominal, loop off, reserved write select
	logic [31:0] t_ctrl [3] = '{32'h8, 32'hc, 32'h8};
	logic [31:0] t_cfg [3] = '{32'h16, 32'h13, 32'h33};
	logic [31:0] t_cmd [3] = '{32'h8, 32'h10, 32'h10};
	logic [31:0] t_err [3] = '{32'h1, 32'h8, 32'h8};

	otc_host #(.RD_GUARD_CK(8), .MOD_CK(4)) uut (
		.clk_sys_i(clk), .arst_n_i(arst_n), .bus_addr_i(bus_addr),
		.bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd),
		.bus_rdata_o(bus_rdata), .odt_o(odt), .dev_cmd_o(cmd),
		.dev_ba_o(ba), .dev_addr_o(daddr), .dev_bc4_o(bc4));
	otc_dev_model #(.WRITE_CAS_LATENCY(5), .AL(0)) dev (
		.clk_sys_i(clk), .rst_n_i(arst_n), .odt_i(odt), .cmd_i(cmd),
		.ba_i(ba), .addr_i(daddr), .bc4_i(bc4), .term_o(term),
		.viol_o(viol));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wrap_up;
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [4:0] a,
		input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		r = bus_rdata;
		chk(nm, e, r & m);
	endtask

	task automatic cmdchk(input logic [31:0] v, input logic [2:0] e);
		wr(otc_pkg::ADDR_CMD, v);
		#1;
		chk("dev_cmd", {29'h0, e}, {29'h0, cmd});
	endtask

	task automatic wait_odt(input logic v, input int lim);
		int n;
		n = 0;
		while (odt !== v && n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("odt_level", {31'h0, v}, {31'h0, odt});
	endtask

	initial
	begin
		#200000;
		mismatches++;
		wrap_up;
	end

	initial
	begin
		arst_n = 1'b0;
		bus_addr = 5'h00;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rchk("ctrl", otc_pkg::ADDR_CTRL, 32'h0, '1);
		rchk("lat", otc_pkg::ADDR_LAT, {19'h0, otc_pkg::AL_RST, 3'h0,
			otc_pkg::CWL_RST}, '1);
		rchk("stat", otc_pkg::ADDR_STAT, 32'h0, '1);
		rchk("unmapped", 5'h18, 32'h0, '1);
		wr(otc_pkg::ADDR_CTRL, 32'h8);
		wr(otc_pkg::ADDR_MRCFG, 32'h13);
		cmdchk(32'h8, otc_pkg::OTC_MRS);
		chk("mr1_ba", 32'h1, {30'h0, ba});
		chk("mr1_nom", 32'h3, {29'h0, daddr[9], daddr[6], daddr[2]});
		cmdchk(32'h10, otc_pkg::OTC_NOP);
		rchk("err_busy", otc_pkg::ADDR_ERR, 32'h40, 32'h40);
		wr(otc_pkg::ADDR_ERR, 32'hff);
		k = 0;
		r = 32'h8;
		while (r[3] !== 1'b0 && k < 30)
		begin
			rchk("stat_any", otc_pkg::ADDR_STAT, 32'h0, 32'h0);
			r = bus_rdata;
			k++;
		end
		chk("settle_end", 32'h0, {31'h0, r[3]});
		cmdchk(32'h10, otc_pkg::OTC_MRS);
		chk("mr2_ba", 32'h2, {30'h0, ba});
		chk("mr2_wsel", 32'h1, {30'h0, daddr[10:9]});
		for (k = 0; k < 3; k++)
		begin
			wr(otc_pkg::ADDR_CTRL, t_ctrl[k]);
			wr(otc_pkg::ADDR_MRCFG, t_cfg[k]);
			cmdchk(t_cmd[k], otc_pkg::OTC_NOP);
			rchk("err_cfg", otc_pkg::ADDR_ERR, t_err[k], t_err[k]);
			wr(otc_pkg::ADDR_ERR, 32'hff);
		end
		wr(otc_pkg::ADDR_CTRL, 32'h8);
		wr(otc_pkg::ADDR_MRCFG, 32'h13);
		for (k = 0; k < 3; k++)
		begin
			wr(otc_pkg::ADDR_CTRL, 32'h9);
			wait_odt(1'b1, 6);
			if (k > 0)
			begin
				cmdchk(k == 1 ? 32'h1 : 32'h3, otc_pkg::OTC_WRITE);
				chk("dev_bc4", {31'h0, k == 2}, {31'h0, bc4});
			end
			wr(otc_pkg::ADDR_CTRL, 32'h8);
			wait_odt(1'b0, 20);
		end
		wr(otc_pkg::ADDR_CTRL, 32'h9);
		wait_odt(1'b1, 6);
		cmdchk(32'h4, otc_pkg::OTC_NOP);
		rchk("err_read", otc_pkg::ADDR_ERR, 32'h2, 32'h2);
		wr(otc_pkg::ADDR_ERR, 32'hff);
		wr(otc_pkg::ADDR_CTRL, 32'h8);
		wait_odt(1'b0, 20);
		cmdchk(32'h4, otc_pkg::OTC_READ);
		wr(otc_pkg::ADDR_CTRL, 32'h9);
		repeat (4)
		begin
			@(posedge clk);
			#1;
			chk("odt_guard", 32'h0, {31'h0, odt});
		end
		wait_odt(1'b1, 20);
		cmdchk(32'h20, otc_pkg::OTC_NOP);
		rchk("err_sref", otc_pkg::ADDR_ERR, 32'h20, 32'h20);
		wr(otc_pkg::ADDR_ERR, 32'hff);
		wr(otc_pkg::ADDR_CTRL, 32'h8);
		wait_odt(1'b0, 20);
		cmdchk(32'h20, otc_pkg::OTC_SRE);
		rchk("stat_sref", otc_pkg::ADDR_STAT, 32'h2, 32'h2);
		cmdchk(32'h40, otc_pkg::OTC_SRX);
		rchk("stat_run", otc_pkg::ADDR_STAT, 32'h0, 32'h2);
		wr(otc_pkg::ADDR_CTRL, 32'ha);
		wait_odt(1'b1, 6);
		cmdchk(32'h8, otc_pkg::OTC_NOP);
		rchk("err_wlvl", otc_pkg::ADDR_ERR, 32'h10, 32'h10);
		wr(otc_pkg::ADDR_ERR, 32'hff);
		wr(otc_pkg::ADDR_CTRL, 32'h8);
		wait_odt(1'b0, 20);
		chk("device_viol", 32'h0, {24'h0, viol});
		wrap_up;
	end
endmodule
`default_nettype wire

// file: otc_dev_model.sv
// otc_dev_model: behavioural device side of the termination pin
`timescale 1ns/1ps
`default_nettype none
module otc_dev_model #(
	parameter int WRITE_CAS_LATENCY = 5,
	parameter int AL = 0
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic odt_i,
	input wire logic [2:0] cmd_i,
	input wire logic [1:0] ba_i,
	input wire logic [12:0] addr_i,
	input wire logic bc4_i,
	output logic [1:0] term_o,
	output logic [7:0] viol_o
);
	// sub-cycle skews fold onto the latency edge; async mode not modelled
	localparam int LAT = WRITE_CAS_LATENCY + AL - 2;
	localparam int RZQ_OHM = 240;
	logic [2:0] nom_r;
	logic [1:0] wsel_r;
	logic sref_r;
	logic odt_r;
	logic wlen_r;
	logic [15:0] pipe_r;
	logic [3:0] hold_r;
	logic [3:0] wcnt_r;
	logic mr1;
	logic mr2;
	logic wcmd;
	logic on;
	logic wact;
	logic bad;

	function automatic int nom_ohms(input logic [2:0] n);
		case (n)
			3'h1: return RZQ_OHM / 4;
			3'h2: return RZQ_OHM / 2;
			3'h3: return RZQ_OHM / 6;
			3'h4: return RZQ_OHM / 12;
			3'h5: return RZQ_OHM / 8;
			default: return 0;
		endcase
	endfunction

	assign mr1 = cmd_i == otc_pkg::OTC_MRS && ba_i == otc_pkg::BA_MR1;
	assign mr2 = cmd_i == otc_pkg::OTC_MRS && ba_i == otc_pkg::BA_MR2;
	assign wcmd = cmd_i == otc_pkg::OTC_WRITE;
	assign on = pipe_r[LAT - 1] && !sref_r;
	assign wact = (|wsel_r) && wcnt_r > LAT
		&& wcnt_r <= LAT + (wlen_r ? 6 : 4);
	// while leveling only the strobe pair would carry the nominal value
	assign term_o = !on ? 2'h0 : wact ? 2'h2
		: (nom_ohms(nom_r) != 0) ? 2'h1 : 2'h0;
	assign bad = (cmd_i == otc_pkg::OTC_READ && odt_i)
		|| (odt_i && (sref_r || cmd_i == otc_pkg::OTC_SRE))
		|| (mr1 && addr_i[9] && addr_i[6])
		|| (wcmd && odt_i && !(|wsel_r)
		&& (nom_r == 3'h4 || nom_r == 3'h5))
		|| (mr1 && addr_i[7] && (|wsel_r))
		|| (!odt_i && odt_r && hold_r != 4'h0);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			nom_r <= 3'h0;
			wsel_r <= 2'h0;
			sref_r <= 1'b0;
			odt_r <= 1'b0;
			wlen_r <= 1'b0;
			pipe_r <= 16'h0000;
			hold_r <= 4'h0;
			wcnt_r <= 4'h0;
			viol_o <= 8'h00;
		end
		else
		begin
			odt_r <= odt_i;
			pipe_r <= {pipe_r[14:0], odt_i};
			viol_o <= viol_o + {7'h0, bad};
			if (mr1)
				nom_r <= {addr_i[9], addr_i[6], addr_i[2]};
			if (mr2)
				wsel_r <= addr_i[10:9];
			if (cmd_i == otc_pkg::OTC_SRE)
				sref_r <= 1'b1;
			else if (cmd_i == otc_pkg::OTC_SRX)
				sref_r <= 1'b0;
			if (wcmd)
			begin
				wcnt_r <= 4'h1;
				wlen_r <= !bc4_i;
			end
			else if (wcnt_r != 4'h0 && wcnt_r != 4'hf)
				wcnt_r <= wcnt_r + 4'h1;
			if (wcmd && odt_i)
				hold_r <= bc4_i ? 4'h3 : 4'h5;
			else if (odt_i && !odt_r)
				hold_r <= 4'h3;
			else if (hold_r != 4'h0)
				hold_r <= hold_r - 4'h1;
		end
endmodule
`default_nettype wire

// file: otc_hold_timer.sv
// otc_hold_timer: least high time of the termination pin
`timescale 1ns/1ps
`default_nettype none
module otc_hold_timer (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	otc_tmr_if.tmr t
);
	logic [7:0] cnt_r;
	logic [7:0] dec;

	assign dec = (cnt_r == 8'h00) ? 8'h00 : cnt_r - 8'h01;
	// a later write may only lengthen the hold, never shorten it
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_r <= 8'h00;
		else if (t.load && (t.val > dec))
			cnt_r <= t.val;
		else
			cnt_r <= dec;
	end

	// the pin may be taken low at the edge where the count reaches zero
	assign t.busy = cnt_r > 8'h01;
endmodule
`default_nettype wire

// file: otc_host.sv
// otc_host: controller that drives the termination pin and mode loads
// Contract
// - never load nominal select codes 110 or 111
// - keep the termination pin low during reads
// - pin high is illegal in self refresh and read; low always legal
// - nominal used for writes must be divide by 2, 4 or 6
// - nominal on only after init and calibration, not in read or refresh
// - pin high, or chopped write with pin high, holds 4 cycles
// - eight-beat write with pin high holds the pin 6 cycles
// - keep write termination off while the delay loop is off
// - single rank may tie pin high, nominal off, write strength on
// - tied case: nominal enabled and disabled in the leveling load
// - tied case: write termination off during write leveling
// - after nominal change, state uncertain for latency, skew, mod, 1
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module otc_host #(
	parameter int RD_GUARD_CK = 8,
	parameter int MOD_CK = 12
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [4:0] bus_addr_i,
	input wire logic [31:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	output logic [31:0] bus_rdata_o,
	output logic odt_o,
	output logic [2:0] dev_cmd_o,
	output logic [1:0] dev_ba_o,
	output logic [12:0] dev_addr_o,
	output logic dev_bc4_o
);
	localparam int ERR_W_LOCAL = otc_pkg::ERR_W;
	localparam logic [7:0] RD_GUARD = 8'(RD_GUARD_CK);
	localparam logic [7:0] MOD_DLY = 8'(MOD_CK);

	logic [1:0] sync_r;
	logic rst_n;
	logic [3:0] ctrl_r;
	logic [4:0] cwl_r;
	logic [4:0] al_r;
	logic [2:0] nom_cfg_r;
	logic [1:0] wr_cfg_r;
	logic wlvl_cfg_r;
	logic [ERR_W_LOCAL-1:0] err_r;
	logic [ERR_W_LOCAL-1:0] err_set;
	logic [2:0] mr1_nom_r;
	logic mr1_wlvl_r;
	logic [1:0] mr2_wr_r;
	logic [2:0] mr1_nom_nxt;
	logic mr1_wlvl_nxt;
	logic [1:0] mr2_wr_nxt;
	otc_pkg::otc_state_t st_r;
	otc_pkg::otc_state_t st_nxt;
	otc_pkg::otc_cmd_t cmd_r;
	otc_pkg::otc_cmd_t cmd_nxt;
	logic [1:0] ba_r;
	logic [1:0] ba_nxt;
	logic [12:0] addr_r;
	logic [12:0] addr_nxt;
	logic bc4_r;
	logic bc4_nxt;
	logic odt_r;
	logic odt_nxt;
	logic odt_want;
	logic [7:0] rd_guard_r;
	logic [31:0] rdata_r;
	logic cmd_go;
	logic tied;
	logic [7:0] odt_lat;

	otc_tmr_if hold_if ();
	otc_tmr_if settle_if ();

	otc_hold_timer u_hold (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.t(hold_if.tmr)
	);

	otc_settle_timer u_settle (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.t(settle_if.tmr)
	);

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sync_r <= 2'b00;
		else
			sync_r <= {sync_r[0], 1'b1};
	end
	assign rst_n = sync_r[1];

	assign tied = ctrl_r[otc_pkg::CTRL_TIED];
	assign cmd_go = bus_wr_i && (bus_addr_i == otc_pkg::ADDR_CMD);
	assign odt_lat = 8'(cwl_r) + 8'(al_r) - otc_pkg::LAT_OFFSET_CK;

	// software registers
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r <= otc_pkg::CTRL_RST;
			cwl_r <= otc_pkg::CWL_RST;
			al_r <= otc_pkg::AL_RST;
			nom_cfg_r <= otc_pkg::NOM_CFG_RST;
			wr_cfg_r <= otc_pkg::WR_CFG_RST;
			wlvl_cfg_r <= 1'b0;
		end
		else if (bus_wr_i && (bus_addr_i == otc_pkg::ADDR_CTRL))
			ctrl_r <= bus_wdata_i[3:0];
		else if (bus_wr_i && (bus_addr_i == otc_pkg::ADDR_LAT))
		begin
			cwl_r <= bus_wdata_i[4:0];
			al_r <= bus_wdata_i[otc_pkg::LAT_AL_LSB +: 5];
		end
		else if (bus_wr_i && (bus_addr_i == otc_pkg::ADDR_MRCFG))
		begin
			nom_cfg_r <= bus_wdata_i[2:0];
			wr_cfg_r <= bus_wdata_i[otc_pkg::MRC_WR_LSB +: 2];
			wlvl_cfg_r <= bus_wdata_i[otc_pkg::MRC_WLVL];
		end
	end

	// sticky refusals; a new refusal beats a clear in the same cycle
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			err_r <= '0;
		else if (bus_wr_i && (bus_addr_i == otc_pkg::ADDR_ERR))
			err_r <= (err_r & ~bus_wdata_i[ERR_W_LOCAL-1:0]) | err_set;
		else
			err_r <= err_r | err_set;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= 32'h0000_0000;
		else if (!bus_rd_i)
			rdata_r <= 32'h0000_0000;
		else if (bus_addr_i == otc_pkg::ADDR_CTRL)
			rdata_r <= {28'h0000000, ctrl_r};
		else if (bus_addr_i == otc_pkg::ADDR_LAT)
			rdata_r <= {19'h00000, al_r, 3'h0, cwl_r};
		else if (bus_addr_i == otc_pkg::ADDR_MRCFG)
			rdata_r <= {23'h000000, wlvl_cfg_r, 2'h0, wr_cfg_r, 1'b0, nom_cfg_r};
		else if (bus_addr_i == otc_pkg::ADDR_STAT)
			rdata_r <= {28'h0000000, settle_if.busy, hold_if.busy, st_r, odt_r};
		else if (bus_addr_i == otc_pkg::ADDR_ERR)
			rdata_r <= {25'h0000000, err_r};
		else
			rdata_r <= 32'h0000_0000;
	end

	// command decision; refused requests only raise an error flag
	always_comb
	begin
		cmd_nxt = otc_pkg::OTC_NOP;
		ba_nxt = ba_r;
		addr_nxt = addr_r;
		bc4_nxt = 1'b0;
		err_set = '0;
		st_nxt = st_r;
		mr1_nom_nxt = mr1_nom_r;
		mr1_wlvl_nxt = mr1_wlvl_r;
		mr2_wr_nxt = mr2_wr_r;
		settle_if.load = 1'b0;
		settle_if.val = odt_lat + otc_pkg::TERM_SKEW_CK + MOD_DLY
			+ otc_pkg::SETTLE_EXTRA_CK;
		if (cmd_go)
		begin
			if (settle_if.busy)
				err_set[otc_pkg::ERR_BUSY] = 1'b1;
			else if (st_r == otc_pkg::OTC_ST_SREF)
			begin
				if (bus_wdata_i[otc_pkg::CMD_SRX])
				begin
					cmd_nxt = otc_pkg::OTC_SRX;
					st_nxt = otc_pkg::OTC_ST_RUN;
				end
				else
					err_set[otc_pkg::ERR_SREF] = 1'b1;
			end
			else if (bus_wdata_i[otc_pkg::CMD_WR])
			begin
				// nominal carried into a write must be a write-legal strength
				if (odt_r && (mr2_wr_r == otc_pkg::WR_OFF)
					&& !otc_pkg::nom_write_ok(mr1_nom_r))
					err_set[otc_pkg::ERR_WR_STR] = 1'b1;
				else
				begin
					cmd_nxt = otc_pkg::OTC_WRITE;
					bc4_nxt = bus_wdata_i[otc_pkg::CMD_BC4];
				end
			end
			else if (bus_wdata_i[otc_pkg::CMD_RD])
			begin
				// tied pin cannot go low, that violation is allowed
				if (odt_r && !tied)
					err_set[otc_pkg::ERR_RD_ODT] = 1'b1;
				else
					cmd_nxt = otc_pkg::OTC_READ;
			end
			else if (bus_wdata_i[otc_pkg::CMD_MR1])
			begin
				if (otc_pkg::nom_reserved(nom_cfg_r))
					err_set[otc_pkg::ERR_NOM_RSVD] = 1'b1;
				else if (tied && ((nom_cfg_r != otc_pkg::NOM_OFF)
					!= wlvl_cfg_r))
					err_set[otc_pkg::ERR_WLVL] = 1'b1;
				else if (tied && wlvl_cfg_r && (mr2_wr_r != otc_pkg::WR_OFF))
					err_set[otc_pkg::ERR_WLVL] = 1'b1;
				else
				begin
					cmd_nxt = otc_pkg::OTC_MRS;
					ba_nxt = otc_pkg::BA_MR1;
					addr_nxt = 13'h0000;
					addr_nxt[otc_pkg::MR1_NOM_B0] = nom_cfg_r[0];
					addr_nxt[otc_pkg::MR1_NOM_B1] = nom_cfg_r[1];
					addr_nxt[otc_pkg::MR1_NOM_B2] = nom_cfg_r[2];
					addr_nxt[otc_pkg::MR1_WLVL] = wlvl_cfg_r;
					mr1_nom_nxt = nom_cfg_r;
					mr1_wlvl_nxt = wlvl_cfg_r;
					settle_if.load = nom_cfg_r != mr1_nom_r;
				end
			end
			else if (bus_wdata_i[otc_pkg::CMD_MR2])
			begin
				if ((wr_cfg_r == otc_pkg::WR_RSVD)
					|| ((wr_cfg_r != otc_pkg::WR_OFF)
					&& (ctrl_r[otc_pkg::CTRL_DLL_OFF]
					|| (tied && mr1_wlvl_r))))
					err_set[otc_pkg::ERR_DYN] = 1'b1;
				else
				begin
					cmd_nxt = otc_pkg::OTC_MRS;
					ba_nxt = otc_pkg::BA_MR2;
					addr_nxt = 13'h0000;
					addr_nxt[otc_pkg::MR2_WR_LSB +: 2] = wr_cfg_r;
					mr2_wr_nxt = wr_cfg_r;
				end
			end
			else if (bus_wdata_i[otc_pkg::CMD_SRE])
			begin
				if (odt_r && !tied)
					err_set[otc_pkg::ERR_SREF] = 1'b1;
				else
				begin
					cmd_nxt = otc_pkg::OTC_SRE;
					st_nxt = otc_pkg::OTC_ST_SREF;
				end
			end
		end
	end

	// pin level; pin and command leave on the same edge
	always_comb
	begin
		if (tied)
			odt_want = 1'b1;
		else
			odt_want = ctrl_r[otc_pkg::CTRL_REQ] && ctrl_r[otc_pkg::CTRL_CAL]
				&& (st_r == otc_pkg::OTC_ST_RUN)
				&& (st_nxt == otc_pkg::OTC_ST_RUN)
				&& (rd_guard_r == 8'h00)
				&& (cmd_nxt != otc_pkg::OTC_READ);
		odt_nxt = odt_r;
		if (odt_want && !odt_r)
			odt_nxt = 1'b1;
		else if (!odt_want && odt_r && !hold_if.busy)
			odt_nxt = 1'b0;
		hold_if.load = (odt_nxt && !odt_r)
			|| ((cmd_nxt == otc_pkg::OTC_WRITE) && odt_nxt);
		if ((cmd_nxt == otc_pkg::OTC_WRITE) && !bc4_nxt)
			hold_if.val = otc_pkg::HOLD_LONG_CK;
		else
			hold_if.val = otc_pkg::HOLD_SHORT_CK;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			odt_r <= 1'b0;
		else
			odt_r <= odt_nxt;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_r <= otc_pkg::OTC_NOP;
			ba_r <= 2'h0;
			addr_r <= 13'h0000;
			bc4_r <= 1'b0;
			st_r <= otc_pkg::OTC_ST_RUN;
		end
		else
		begin
			cmd_r <= cmd_nxt;
			ba_r <= ba_nxt;
			addr_r <= addr_nxt;
			bc4_r <= bc4_nxt;
			st_r <= st_nxt;
		end
	end

	// shadows of what the device was last loaded with
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mr1_nom_r <= otc_pkg::NOM_OFF;
			mr1_wlvl_r <= 1'b0;
			mr2_wr_r <= otc_pkg::WR_OFF;
		end
		else
		begin
			mr1_nom_r <= mr1_nom_nxt;
			mr1_wlvl_r <= mr1_wlvl_nxt;
			mr2_wr_r <= mr2_wr_nxt;
		end
	end

	// read data is driven for a while after the command, keep the pin low
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			rd_guard_r <= 8'h00;
		else if (cmd_nxt == otc_pkg::OTC_READ)
			rd_guard_r <= RD_GUARD;
		else if (rd_guard_r != 8'h00)
			rd_guard_r <= rd_guard_r - 8'h01;
	end

	assign bus_rdata_o = rdata_r;
	assign odt_o = odt_r;
	assign dev_cmd_o = cmd_r;
	assign dev_ba_o = ba_r;
	assign dev_addr_o = addr_r;
	assign dev_bc4_o = bc4_r;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	property p_rise_hold;
		$rose(odt_o) |-> odt_o [*4];
	endproperty
	a_rise_hold: assert property (p_rise_hold)
		else $error("pin dropped before four cycles");

	property p_bl8_hold;
		(dev_cmd_o == otc_pkg::OTC_WRITE && !dev_bc4_o && odt_o)
			|-> odt_o [*6];
	endproperty
	a_bl8_hold: assert property (p_bl8_hold)
		else $error("pin dropped before six cycles after write");

	property p_rd_low;
		(dev_cmd_o == otc_pkg::OTC_READ && !tied) |-> !odt_o [*4];
	endproperty
	a_rd_low: assert property (p_rd_low)
		else $error("pin high around a read");

	property p_nom_rsvd;
		(dev_cmd_o == otc_pkg::OTC_MRS && dev_ba_o == otc_pkg::BA_MR1)
			|-> !(dev_addr_o[otc_pkg::MR1_NOM_B2]
			&& dev_addr_o[otc_pkg::MR1_NOM_B1]);
	endproperty
	a_nom_rsvd: assert property (p_nom_rsvd)
		else $error("reserved nominal code loaded");

	property p_wr_str;
		(dev_cmd_o == otc_pkg::OTC_WRITE && odt_o
			&& mr2_wr_r == otc_pkg::WR_OFF)
			|-> otc_pkg::nom_write_ok(mr1_nom_r);
	endproperty
	a_wr_str: assert property (p_wr_str)
		else $error("write under illegal nominal strength");

	property p_dll_dyn;
		(dev_cmd_o == otc_pkg::OTC_MRS && dev_ba_o == otc_pkg::BA_MR2
			&& ctrl_r[otc_pkg::CTRL_DLL_OFF])
			|-> dev_addr_o[otc_pkg::MR2_WR_LSB +: 2] == otc_pkg::WR_OFF;
	endproperty
	a_dll_dyn: assert property (p_dll_dyn)
		else $error("write termination enabled with loop off");

	property p_sref_low;
		(st_r == otc_pkg::OTC_ST_SREF && !tied) |-> !odt_o;
	endproperty
	a_sref_low: assert property (p_sref_low)
		else $error("pin high in self refresh");

	property p_cal;
		($rose(odt_o) && !tied) |-> $past(ctrl_r[otc_pkg::CTRL_CAL]);
	endproperty
	a_cal: assert property (p_cal)
		else $error("pin raised before calibration");

	property p_tied;
		tied |=> odt_o;
	endproperty
	a_tied: assert property (p_tied)
		else $error("tied mode pin not high");

	property p_settle;
		settle_if.load |=> settle_if.busy [*2];
	endproperty
	a_settle: assert property (p_settle)
		else $error("settle window not opened");

	property p_wlvl;
		(tied && mr1_wlvl_r) |-> mr2_wr_r == otc_pkg::WR_OFF;
	endproperty
	a_wlvl: assert property (p_wlvl)
		else $error("write termination on during leveling");
endmodule
`default_nettype wire

// file: otc_pkg.sv
// otc_pkg: constants and types of the termination pin controller
package otc_pkg;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_LAT = 5'h04;
	localparam logic [4:0] ADDR_MRCFG = 5'h08;
	localparam logic [4:0] ADDR_CMD = 5'h0c;
	localparam logic [4:0] ADDR_STAT = 5'h10;
	localparam logic [4:0] ADDR_ERR = 5'h14;

	localparam int CTRL_REQ = 0;
	localparam int CTRL_TIED = 1;
	localparam int CTRL_DLL_OFF = 2;
	localparam int CTRL_CAL = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;

	localparam int LAT_AL_LSB = 8;
	localparam logic [4:0] CWL_RST = 5'h05;
	localparam logic [4:0] AL_RST = 5'h00;

	localparam int MRC_WR_LSB = 4;
	localparam int MRC_WLVL = 8;
	localparam logic [2:0] NOM_CFG_RST = 3'h0;
	localparam logic [1:0] WR_CFG_RST = 2'h0;

	localparam int CMD_WR = 0;
	localparam int CMD_BC4 = 1;
	localparam int CMD_RD = 2;
	localparam int CMD_MR1 = 3;
	localparam int CMD_MR2 = 4;
	localparam int CMD_SRE = 5;
	localparam int CMD_SRX = 6;

	localparam int ERR_NOM_RSVD = 0;
	localparam int ERR_RD_ODT = 1;
	localparam int ERR_WR_STR = 2;
	localparam int ERR_DYN = 3;
	localparam int ERR_WLVL = 4;
	localparam int ERR_SREF = 5;
	localparam int ERR_BUSY = 6;
	localparam int ERR_W = 7;

	localparam int MR1_NOM_B0 = 2;
	localparam int MR1_NOM_B1 = 6;
	localparam int MR1_NOM_B2 = 9;
	localparam int MR1_WLVL = 7;
	localparam int MR2_WR_LSB = 9;
	localparam logic [1:0] BA_MR1 = 2'h1;
	localparam logic [1:0] BA_MR2 = 2'h2;

	localparam logic [2:0] NOM_OFF = 3'h0;
	localparam logic [2:0] NOM_DIV12 = 3'h4;
	localparam logic [2:0] NOM_DIV8 = 3'h5;
	localparam logic [1:0] WR_OFF = 2'h0;
	localparam logic [1:0] WR_RSVD = 2'h3;

	localparam logic [7:0] HOLD_SHORT_CK = 8'h04;
	localparam logic [7:0] HOLD_LONG_CK = 8'h06;
	localparam logic [7:0] LAT_OFFSET_CK = 8'h02;
	localparam logic [7:0] SETTLE_EXTRA_CK = 8'h01;
	// turn-off skew is at most 0.7 of a clock period
	localparam int TERM_SKEW_TENTHS_CK = 7;
	localparam logic [7:0] TERM_SKEW_CK = 8'((TERM_SKEW_TENTHS_CK + 9) / 10);

	typedef enum logic [2:0] {
		OTC_NOP = 3'b000,
		OTC_WRITE = 3'b001,
		OTC_READ = 3'b010,
		OTC_MRS = 3'b011,
		OTC_SRE = 3'b100,
		OTC_SRX = 3'b101
	} otc_cmd_t;

	typedef enum logic {
		OTC_ST_RUN = 1'b0,
		OTC_ST_SREF = 1'b1
	} otc_state_t;

	function automatic logic nom_reserved(input logic [2:0] n);
		return n[2] & n[1];
	endfunction

	function automatic logic nom_write_ok(input logic [2:0] n);
		return !((n == NOM_DIV12) || (n == NOM_DIV8));
	endfunction
endpackage

// file: otc_settle_timer.sv
// otc_settle_timer: window of uncertain termination after a load that changes the nominal select
`timescale 1ns/1ps
`default_nettype none
module otc_settle_timer (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	otc_tmr_if.tmr t
);
	logic [7:0] cnt_r;

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_r <= 8'h00;
		else if (t.load)
			cnt_r <= t.val;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
	end

	assign t.busy = cnt_r != 8'h00;
endmodule
`default_nettype wire

// file: otc_tmr_if.sv
// otc_tmr_if: load and busy handshake between controller and its timers
`timescale 1ns/1ps
`default_nettype none
interface otc_tmr_if;
	logic load;
	logic [7:0] val;
	logic busy;
	modport ctl (output load, output val, input busy);
	modport tmr (input load, input val, output busy);
endinterface
`default_nettype wire
